// ### rtl/sbl_defines.svh
// constants for the serial configuration port: addresses, bit positions, counts
// assumes inclusion by bare name from the package, whose macros the top module then uses
`ifndef SBL_DEFINES_SVH
`define SBL_DEFINES_SVH
`define SBL_ADDR_WR 8'hD2
`define SBL_ADDR_RD 8'hD3
`define SBL_CMD_BYTE_BIT 7
`define SBL_IDX_W 7
`define SBL_CTRL_IDX 7'h00
`define SBL_BIT_WEN 0
`define SBL_BIT_FS_LO 1
`define SBL_BIT_FS_HI 5
`define SBL_BIT_SPREAD 6
`define SBL_BIT_WDIS 7
`define SBL_FS_W 5
`define SBL_LAST_BIT 4'h7
`define SBL_ACK_SLOT 4'h8
`define SBL_STRAP_SETTLE 2'h3
`define SBL_UNMAPPED_DATA 8'h00
`endif

// ### rtl/sbl_pkg.sv
// types shared by the serial configuration port
// assumes sbl_defines.svh is on the include path
package sbl_pkg;
  `include "sbl_defines.svh"
  typedef struct packed {
    logic spread;
    logic [`SBL_FS_W-1:0] fs;
  } sbl_strap_t;
  typedef struct packed {
    logic spread_en;
    logic [`SBL_FS_W-1:0] fs;
    logic write_locked;
    logic write_enabled;
  } sbl_cfg_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_CMD = 6'h04,
    ST_WDATA = 6'h08,
    ST_RDATA = 6'h10,
    ST_IGNORE = 6'h20
  } sbl_state_t;
endpackage

// ### rtl/sbl_top.sv
// serial slave port of the clock synthesizer with its control byte at index 0
// assumes scl, sda and straps come from pins; i_clk is much faster than scl
// Behaviour
// - command msb set means single byte access, low seven bits index it
// - byte write is address, command, one data byte, each acked, then stop
// - byte read uses repeated start, read address, one byte, host nack
// - answer write address D2 and read address D3
// - bit 7 set after bit 0 set locks all registers until reset
// - once locked, writes are still acked but change nothing
// - writing 1 to bit 0 unlocks configuration writes
// - writing 0 to bit 0 relocks all except bit 0 itself
// - while locked, block writes complete on the bus with no effect
// - an unlock bit change takes effect from the next command on
// - spreading is on when software bit 6 or spread strap is 1
// - reading bit 6 returns the spread strap, not the written value
// - bits 4 to 1 are frequency selects loaded from straps at power-up
// - bit 5 is an extra frequency select, loaded from its strap
// - command zero is a block access starting from index zero
// - all registers load defaults at reset, no programming required
`timescale 1ns/1ps
module sbl_top #(
  parameter int NUM_BYTES = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire sbl_pkg::sbl_strap_t i_strap,
  output sbl_pkg::sbl_cfg_t o_cfg
);
  import sbl_pkg::*;

  generate
    if (NUM_BYTES < 1 || NUM_BYTES > 127) begin : g_bad
      $error("NUM_BYTES must be 1 to 127");
    end
  endgenerate

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_meta_r;
  logic [1:0] sda_meta_r;
  sbl_strap_t strap_meta_r;
  sbl_strap_t strap_s_r;
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_meta_r <= 2'h3;
      sda_meta_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_meta_r <= {scl_meta_r[0], i_scl};
      sda_meta_r <= {sda_meta_r[0], i_sda};
      scl_d_r <= scl_meta_r[1];
      sda_d_r <= sda_meta_r[1];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      strap_meta_r <= '0;
      strap_s_r <= '0;
    end else begin
      strap_meta_r <= i_strap;
      strap_s_r <= strap_meta_r;
    end
  end

  assign scl_s = scl_meta_r[1];
  assign sda_s = sda_meta_r[1];

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ----------------------------------------------------------------
  // transaction state
  // ----------------------------------------------------------------
  sbl_state_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [`SBL_IDX_W-1:0] idx_r;
  logic block_r;
  logic cnt_pend_r;
  logic ack_go_r;
  logic eff_en_r;
  logic [7:0] byte_in;
  logic byte_done;
  logic wr_now;
  logic [7:0] rd_byte;
  logic [7:0] tx_next;
  logic load_cnt;

  // control byte state
  logic wen_r;
  logic wdis_r;
  logic sw_spread_r;
  logic [`SBL_FS_W-1:0] fs_r;
  logic [1:0] settle_r;

  assign byte_in = {rx_r[6:0], sda_s};
  assign byte_done = scl_rise && cnt_r == `SBL_LAST_BIT;
  // the byte count of a block write is swallowed before the data bytes
  assign wr_now = byte_done && st_r == ST_WDATA && !cnt_pend_r;

  always_comb begin
    if (idx_r == `SBL_CTRL_IDX) begin
      rd_byte = {wdis_r, strap_s_r.spread, fs_r, wen_r};
    end else begin
      rd_byte = `SBL_UNMAPPED_DATA;
    end
  end

  // a block read answers with its byte count before the data
  assign load_cnt = block_r && cnt_pend_r;
  assign tx_next = load_cnt ? 8'(NUM_BYTES) : rd_byte;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      idx_r <= '0;
      block_r <= 1'b0;
      cnt_pend_r <= 1'b0;
      ack_go_r <= 1'b0;
      eff_en_r <= 1'b0;
    end else if (start_ev) begin
      // repeated start keeps the index and block mode of the command
      st_r <= ST_ADDR;
      cnt_r <= 4'h0;
      ack_go_r <= 1'b0;
    end else if (stop_ev) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      ack_go_r <= 1'b0;
    end else if (scl_rise && st_r != ST_IDLE) begin
      if (cnt_r == `SBL_ACK_SLOT) begin
        cnt_r <= 4'h0;
        // the slot after the read address carries our own ack, not the host's
        if (st_r == ST_RDATA && !ack_go_r) begin
          if (sda_s) begin
            st_r <= ST_IGNORE;
          end else begin
            tx_r <= tx_next;
            if (load_cnt) begin
              cnt_pend_r <= 1'b0;
            end else begin
              idx_r <= idx_r + 1'b1;
            end
          end
        end
      end else begin
        rx_r <= byte_in;
        cnt_r <= cnt_r + 4'h1;
        if (byte_done) begin
          ack_go_r <= 1'b0;
          case (st_r)
            ST_ADDR: begin
              if (byte_in == `SBL_ADDR_WR) begin
                st_r <= ST_CMD;
                ack_go_r <= 1'b1;
              end else if (byte_in == `SBL_ADDR_RD) begin
                st_r <= ST_RDATA;
                ack_go_r <= 1'b1;
                tx_r <= tx_next;
                if (load_cnt) begin
                  cnt_pend_r <= 1'b0;
                end else begin
                  idx_r <= idx_r + 1'b1;
                end
              end else begin
                st_r <= ST_IGNORE;
              end
            end
            ST_CMD: begin
              st_r <= ST_WDATA;
              ack_go_r <= 1'b1;
              // unlock state is sampled once per command
              eff_en_r <= wen_r & ~wdis_r;
              if (byte_in[`SBL_CMD_BYTE_BIT]) begin
                idx_r <= byte_in[`SBL_IDX_W-1:0];
                block_r <= 1'b0;
                cnt_pend_r <= 1'b0;
              end else begin
                idx_r <= '0;
                block_r <= 1'b1;
                cnt_pend_r <= 1'b1;
              end
            end
            ST_WDATA: begin
              ack_go_r <= 1'b1;
              if (cnt_pend_r) begin
                cnt_pend_r <= 1'b0;
              end else begin
                idx_r <= idx_r + 1'b1;
              end
            end
            default: begin
              ack_go_r <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // sda drive, changed only while scl is low
  // ----------------------------------------------------------------
  logic [2:0] tx_sel;
  assign tx_sel = 3'h7 - cnt_r[2:0];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sda_oe <= 1'b0;
    end else if (start_ev || stop_ev) begin
      o_sda_oe <= 1'b0;
    end else if (scl_fall) begin
      if (cnt_r == `SBL_ACK_SLOT) begin
        o_sda_oe <= ack_go_r;
      end else if (st_r == ST_RDATA) begin
        o_sda_oe <= ~tx_r[tx_sel];
      end else begin
        o_sda_oe <= 1'b0;
      end
    end
  end

  // open drain: only ever pulls low
  assign o_sda_o = 1'b0;

  // ----------------------------------------------------------------
  // control byte
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      settle_r <= 2'h0;
    end else if (settle_r != `SBL_STRAP_SETTLE) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wen_r <= 1'b0;
      wdis_r <= 1'b0;
      sw_spread_r <= 1'b0;
      fs_r <= '0;
    end else if (settle_r != `SBL_STRAP_SETTLE) begin
      // straps are taken once they have passed the synchroniser
      fs_r <= strap_s_r.fs;
    end else if (wr_now && idx_r == `SBL_CTRL_IDX && !wdis_r) begin
      wen_r <= byte_in[`SBL_BIT_WEN];
      if (eff_en_r) begin
        fs_r <= byte_in[`SBL_BIT_FS_HI:`SBL_BIT_FS_LO];
        sw_spread_r <= byte_in[`SBL_BIT_SPREAD];
        if (byte_in[`SBL_BIT_WDIS]) begin
          wdis_r <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // spread request is registered so every field of o_cfg leaves a flop;
  // it trails the strap pin by one more cycle than the read-back copy
  logic spread_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      spread_r <= 1'b0;
    end else begin
      spread_r <= sw_spread_r | strap_s_r.spread;
    end
  end

  assign o_cfg.spread_en = spread_r;
  assign o_cfg.fs = fs_r;
  assign o_cfg.write_locked = wdis_r;
  assign o_cfg.write_enabled = wen_r;
endmodule

// ### verification/sbl_props.sv
// assertions on the serial configuration port, bound to its top module
// assumes straps only move while reset is held
`timescale 1ns/1ps
module sbl_props #(
  parameter int NUM_BYTES = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire sbl_pkg::sbl_strap_t i_strap,
  input wire sbl_pkg::sbl_cfg_t o_cfg
);
  import sbl_pkg::*;
  logic [2:0] age_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // strap loading may move fs freely in the first edges after reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end
  a_reset_clears: assert property ($past(i_rst) |->
    !o_cfg.write_locked && !o_cfg.write_enabled && !o_sda_oe) else $error("reset value");
  a_fs_from_strap: assert property (age_r == 3'h6 |->
    o_cfg.fs == $past(i_strap.fs, 6)) else $error("fs not strapped");
  a_spread_strap: assert property (age_r == 3'h7 && $past(i_strap.spread, 3)
    |-> o_cfg.spread_en) else $error("spread off");
  a_lock_sticky: assert property (o_cfg.write_locked |=> o_cfg.write_locked)
    else $error("lock fell");
  a_lock_needs_en: assert property ($rose(o_cfg.write_locked) |->
    o_cfg.write_enabled && $past(o_cfg.write_enabled)) else $error("lock without unlock");
  a_locked_frozen: assert property (o_cfg.write_locked |=>
    $stable({o_cfg.fs, o_cfg.write_enabled})) else $error("locked reg moved");
  a_fs_needs_en: assert property (age_r == 3'h7 && $changed(o_cfg.fs)
    |-> $past(o_cfg.write_enabled)) else $error("fs moved while relocked");
  a_sda_scl_low: assert property ($changed(o_sda_oe) |->
    !i_scl && !$past(i_scl) && !o_sda_o) else $error("sda moved in scl high");
  cover property ($rose(o_cfg.write_locked));
  cover property ($fell(o_cfg.write_enabled));
  cover property ($rose(o_sda_oe) ##[1:60] $fell(o_sda_oe));
endmodule
bind sbl_top sbl_props #(.NUM_BYTES(NUM_BYTES)) u_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
  .i_strap(i_strap), .o_cfg(o_cfg));

// ### verification/sbl_host.sv
// bus host model: makes the bus clock and pulls data low, open drain
// assumes a pull-up resolves sda; clock stands high between frames
`timescale 1ns/1ps
module sbl_host (
  output logic o_scl,
  output logic o_pull,
  input wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_pull = 1'b0;
  end
  // 24 ns before scl rises lets the slave drop its ack first
  task automatic start();
    o_pull = 1'b0;
    #24 o_scl = 1'b1;
    #12 o_pull = 1'b1;
    #12 o_scl = 1'b0;
  endtask
  task automatic stop();
    #12 o_pull = 1'b1;
    #12 o_scl = 1'b1;
    #12 o_pull = 1'b0;
    #24;
  endtask
  task automatic bit_x(input logic b, output logic r);
    #12 o_pull = ~b;
    #12 o_scl = 1'b1;
    #12 r = i_sda;
    #12 o_scl = 1'b0;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rx(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(1'b1, r);
  endtask
endmodule

// ### verification/tb.sv
// self-checking bench for the serial configuration port
// assumes sbl_host as bus master and sbl_props bound to the top
`timescale 1ns/1ps
module tb;
  import sbl_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic scl, pull, sda, sda_o, sda_oe, ack;
  sbl_strap_t i_strap = '0;
  sbl_cfg_t o_cfg;
  logic [7:0] rdv;
  logic [16:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;
  event chk_ev;
  always #2.5 i_clk = ~i_clk;
  assign sda = ~pull & (~sda_oe | sda_o);
  sbl_top #(.NUM_BYTES(1)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_strap(i_strap), .o_cfg(o_cfg));
  sbl_host host (.o_scl(scl), .o_pull(pull), .i_sda(sda));
  function automatic logic [16:0] mk(logic a, logic [7:0] r, logic sp, logic [4:0] f,
    logic lk, logic we);
    return {a, r, sp, f, lk, we};
  endfunction
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // host edges land on whole ns, never on a rising clock edge
  task automatic xact(input logic [7:0] a, c, d, input logic rd, input logic [16:0] e);
    logic k1, k2, k3;
    logic [7:0] r;
    r = 8'h00;
    @(negedge i_clk);
    host.start();
    host.tx(a, k1);
    host.tx(c, k2);
    if (rd) begin
      host.start();
      host.tx(8'hD3, k3);
      host.rx(r);
    end else begin
      if (c == 8'h00) host.tx(8'h01, k3);
      host.tx(d, k3);
    end
    host.stop();
    repeat (4) @(posedge i_clk);
    ack = k1 & k2 & k3;
    rdv = r;
    exp_q.push_back(e);
    -> chk_ev;
  endtask
  always @(chk_ev) begin
    check({ack, rdv, o_cfg}, exp_q.pop_front());
    $display("test %0d done", checked);
  end
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
  initial begin
    logic s;
    logic [4:0] f, r;
    void'($urandom(12));
    @(posedge i_clk) i_strap <= 6'($urandom);
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_clk);
    s = i_strap.spread;
    f = i_strap.fs;
    r = 5'($urandom);
    xact(8'hA4, 8'h80, 8'h3F, 1'b0, mk(0, 8'h00, s, f, 0, 0));
    xact(8'hD2, 8'h80, 8'h7E, 1'b0, mk(1, 8'h00, s, f, 0, 0));
    xact(8'hD2, 8'h80, 8'h01, 1'b0, mk(1, 8'h00, s, f, 0, 1));
    xact(8'hD2, 8'h80, {2'b01, r, 1'b1}, 1'b0, mk(1, 8'h00, 1, r, 0, 1));
    xact(8'hD2, 8'h80, 8'h00, 1'b1, mk(1, {1'b0, s, r, 1'b1}, 1, r, 0, 1));
    xact(8'hD2, 8'h80, 8'h00, 1'b0, mk(1, 8'h00, s, 0, 0, 0));
    xact(8'hD2, 8'h80, 8'h3F, 1'b0, mk(1, 8'h00, s, 0, 0, 1));
    xact(8'hD2, 8'h00, {2'b00, r, 1'b1}, 1'b0, mk(1, 8'h00, s, r, 0, 1));
    xact(8'hD2, 8'h80, {2'b10, r, 1'b1}, 1'b0, mk(1, 8'h00, s, r, 1, 1));
    xact(8'hD2, 8'h80, 8'h00, 1'b0, mk(1, 8'h00, s, r, 1, 1));
    xact(8'hD2, 8'h80, 8'h00, 1'b1, mk(1, {1'b1, s, r, 1'b1}, s, r, 1, 1));
    @(posedge i_clk);
    final_report();
  end
endmodule
